// file: src/hcs_pkg.sv
package hcs_pkg;
    // register byte offsets
    localparam logic [7:0] HCS_OFF_CONFIG  = 8'h10;
    localparam logic [7:0] HCS_OFF_EEP_CMD = 8'h40;
    localparam logic [7:0] HCS_OFF_IRQ_STS = 8'h44;
    localparam logic [7:0] HCS_OFF_IRQ_EN  = 8'h48;
    localparam logic [7:0] HCS_OFF_IRQ_CLR = 8'h4C;
    // hardware_config_reg fields
    localparam int HCS_B_FULL_RST   = 0;
    localparam int HCS_B_LITE_RST   = 1;
    localparam int HCS_B_TO_SEL     = 3;
    localparam int HCS_B_MFP        = 4;
    localparam int HCS_B_SUSP_POL   = 5;
    localparam int HCS_B_SUSP_SEL   = 6;
    localparam int HCS_B_DETACH     = 15;
    localparam int HCS_B_LED        = 20;
    // eeprom_command_reg fields
    localparam int HCS_B_EEP_TO     = 0;
    localparam int HCS_B_EEP_BUSY   = 1;
    // interrupt bits
    localparam int HCS_IRQ_W        = 4;
    localparam int HCS_I_EEP_TO     = 0;
    localparam int HCS_I_LITE_DONE  = 1;
    localparam int HCS_I_FULL_DONE  = 2;
    localparam int HCS_I_DETACH     = 3;
    // reset values of software fields
    localparam logic [1:0] HCS_RST_SEL  = 2'h0;
    localparam logic       HCS_RST_POL  = 1'h0;
    localparam logic [3:0] HCS_RST_LED  = 4'h0;
    localparam logic       HCS_RST_MFP  = 1'h0;
    localparam logic       HCS_RST_TO   = 1'h0;
    localparam logic [HCS_IRQ_W-1:0] HCS_RST_IRQ = 4'h0;
    // timing
    localparam int HCS_CLK_NS         = 5;
    localparam int HCS_EEP_TO_LONG_NS = 30000000;
    localparam int HCS_EEP_TO_SHRT_NS = 1280;
    localparam int HCS_EEP_TO_LONG_CYC = HCS_EEP_TO_LONG_NS / HCS_CLK_NS;
    localparam int HCS_EEP_TO_SHRT_CYC = HCS_EEP_TO_SHRT_NS / HCS_CLK_NS;

    typedef enum logic [1:0]
    {
        HCS_SEQ_IDLE = 2'b00,
        HCS_SEQ_LITE = 2'b01,
        HCS_SEQ_FULL = 2'b10
    } hcs_seq_e;
endpackage

// file: src/hcs_top.sv
// Behaviour
// - suspend select 00 state2; 01 +state1,detach; 10 +state0; 11 +state3
// - polarity 0 drives asserted pin low, 1 drives it high
// - suspend fields act regardless of eeprom presence or emulation
// - packing bit enables multi-frame usb packets; resets to zero
// - eeprom time-out after 30 ms (select 0) or 1.28 us (select 1)
// - time-out sets the flag in the eeprom command register
// - lite reset bit set by writing 1, clears when sequence completes
// - lite reset leaves usb, phy connection and eeprom alone
// - full reset bit starts reset with eeprom reload, self-clears
// - phy held disconnected during full reset, released afterwards
// - power-up suspend and led fields from loaded image, else zero
// - usb or lite reset restores those fields from last image
// - cable-detach flag set only when a detach event occurred
// - suspend fields are covered by the reset guard
// - with guard set protected fields survive all but power-on reset
// - hardware config register at offset 010h, 32 bits
`timescale 1ns/10ps
module hcs_top
    import hcs_pkg::*;
#(
    parameter int TO_LONG_CYC = HCS_EEP_TO_LONG_CYC
)
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_ce,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    input  wire logic        i_low_power,
    input  wire logic [1:0]  i_power_state,
    input  wire logic        i_cable_detach,
    input  wire logic        i_detach_event,
    input  wire logic        i_image_load,
    input  wire logic        i_image_valid,
    input  wire logic [1:0]  i_image_sel,
    input  wire logic        i_image_pol,
    input  wire logic [3:0]  i_image_led,
    input  wire logic        i_usb_reset,
    input  wire logic        i_reset_guard,
    input  wire logic        i_lite_done,
    input  wire logic        i_full_done,
    input  wire logic        i_eep_start,
    input  wire logic        i_eep_resp,
    output logic             o_lite_reset,
    output logic             o_full_reset,
    output logic             o_phy_disconnect,
    output logic             o_eeprom_reload,
    output logic             o_eep_timeout,
    output logic             o_suspend_pin,
    output logic             o_multi_frame,
    output logic      [3:0]  o_led_enable,
    output logic             o_irq
);
    localparam int TW = $clog2(TO_LONG_CYC + 1);
    localparam logic [TW-1:0] TO_LONG  = TW'(TO_LONG_CYC - 1);
    localparam logic [TW-1:0] TO_SHORT = TW'(HCS_EEP_TO_SHRT_CYC - 1);

    // one-hot register hit: 0 cfg, 1 eep, 2 sts, 3 en, 4 clr
    function automatic logic [4:0] reg_hit(input logic [31:0] a);
        logic [4:0] h;
        h = 5'h00;
        if (a[31:8] == 24'h000000)
        begin
            h[0] = (a[7:0] == HCS_OFF_CONFIG);
            h[1] = (a[7:0] == HCS_OFF_EEP_CMD);
            h[2] = (a[7:0] == HCS_OFF_IRQ_STS);
            h[3] = (a[7:0] == HCS_OFF_IRQ_EN);
            h[4] = (a[7:0] == HCS_OFF_IRQ_CLR);
        end
        return h;
    endfunction

    logic rst_s1_reg;
    logic rst_b_reg;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_s1_reg <= 1'b0;
            rst_b_reg  <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_b_reg  <= rst_s1_reg;
        end
    end

    logic [1:0]           sel_reg,    sel_next;
    logic                 pol_reg,    pol_next;
    logic [3:0]           led_reg,    led_next;
    logic                 mfp_reg,    mfp_next;
    logic                 tos_reg,    tos_next;
    logic                 det_reg,    det_next;
    logic [1:0]           isel_reg,   isel_next;
    logic                 ipol_reg,   ipol_next;
    logic [3:0]           iled_reg,   iled_next;
    logic                 booted_reg, booted_next;
    hcs_seq_e             seq_reg,    seq_next;
    logic                 eto_reg,    eto_next;
    logic                 ebusy_reg,  ebusy_next;
    logic [TW-1:0]        ecnt_reg,   ecnt_next;
    logic [HCS_IRQ_W-1:0] sts_reg,    sts_next;
    logic [HCS_IRQ_W-1:0] en_reg,     en_next;
    logic                 wp_reg,     wp_next;
    logic [4:0]           wh_reg,     wh_next;
    logic [31:0]          rd_next;
    logic                 susp_next;
    logic                 rld_next;
    logic                 etp_next;

    always_comb
    begin
        logic       ap;
        logic [4:0] rh;
        logic [HCS_IRQ_W-1:0] ev;
        logic       act;
        logic       restore;
        logic       lite_go;
        logic       full_go;
        ap      = i_hsel & i_hready & i_htrans[1];
        rh      = reg_hit(i_haddr);
        ev      = '0;
        act     = 1'b0;
        restore = 1'b0;
        lite_go = 1'b0;
        full_go = 1'b0;
        sel_next    = sel_reg;
        pol_next    = pol_reg;
        led_next    = led_reg;
        mfp_next    = mfp_reg;
        tos_next    = tos_reg;
        det_next    = det_reg;
        isel_next   = isel_reg;
        ipol_next   = ipol_reg;
        iled_next   = iled_reg;
        booted_next = booted_reg;
        seq_next    = seq_reg;
        eto_next    = eto_reg;
        ebusy_next  = ebusy_reg;
        ecnt_next   = ecnt_reg;
        sts_next    = sts_reg;
        en_next     = en_reg;
        rld_next    = 1'b0;
        etp_next    = 1'b0;
        wp_next     = ap & i_hwrite;
        wh_next     = ap ? rh : 5'h00;

        // data phase of a write; reserved bits are simply not stored
        if (wp_reg && wh_reg[0])
        begin
            sel_next = i_hwdata[HCS_B_SUSP_SEL +: 2];
            pol_next = i_hwdata[HCS_B_SUSP_POL];
            led_next = i_hwdata[HCS_B_LED +: 4];
            mfp_next = i_hwdata[HCS_B_MFP];
            tos_next = i_hwdata[HCS_B_TO_SEL];
            if (i_hwdata[HCS_B_DETACH])
                det_next = 1'b0;
            full_go  = i_hwdata[HCS_B_FULL_RST];
            lite_go  = i_hwdata[HCS_B_LITE_RST];
        end
        if (wp_reg && wh_reg[1] && i_hwdata[HCS_B_EEP_TO])
            eto_next = 1'b0;
        if (wp_reg && wh_reg[3])
            en_next = i_hwdata[HCS_IRQ_W-1:0];
        if (wp_reg && wh_reg[4])
            sts_next = sts_reg & ~i_hwdata[HCS_IRQ_W-1:0];

        // reset sequencer; a request while busy is ignored
        case (seq_reg)
            HCS_SEQ_IDLE:
            begin
                if (full_go)
                begin
                    seq_next = HCS_SEQ_FULL;
                    rld_next = 1'b1;
                    mfp_next = HCS_RST_MFP;
                    tos_next = HCS_RST_TO;
                end
                else if (lite_go)
                begin
                    // usb, phy and eeprom are not touched here
                    seq_next = HCS_SEQ_LITE;
                    restore  = 1'b1;
                    mfp_next = HCS_RST_MFP;
                    tos_next = HCS_RST_TO;
                end
            end
            HCS_SEQ_LITE:
            begin
                if (i_lite_done)
                begin
                    seq_next = HCS_SEQ_IDLE;
                    ev[HCS_I_LITE_DONE] = 1'b1;
                end
            end
            HCS_SEQ_FULL:
            begin
                if (i_full_done)
                begin
                    seq_next = HCS_SEQ_IDLE;
                    ev[HCS_I_FULL_DONE] = 1'b1;
                end
            end
            default:
                seq_next = HCS_SEQ_IDLE;
        endcase

        // image capture; absent image means all zero
        if (i_image_load)
        begin
            isel_next = i_image_valid ? i_image_sel : HCS_RST_SEL;
            ipol_next = i_image_valid ? i_image_pol : HCS_RST_POL;
            iled_next = i_image_valid ? i_image_led : HCS_RST_LED;
            booted_next = 1'b1;
        end
        if (i_usb_reset)
            restore = 1'b1;
        // first image after power-on always applies
        if (i_image_load && (!booted_reg || !i_reset_guard))
        begin
            sel_next = isel_next;
            pol_next = ipol_next;
            led_next = iled_next;
        end
        else if (restore && !i_reset_guard)
        begin
            sel_next = isel_reg;
            pol_next = ipol_reg;
            led_next = iled_reg;
        end

        // eeprom response timer
        if (i_eep_start)
        begin
            ebusy_next = 1'b1;
            ecnt_next  = '0;
        end
        else if (ebusy_reg)
        begin
            if (i_eep_resp)
                ebusy_next = 1'b0;
            else if (ecnt_reg == (tos_reg ? TO_SHORT : TO_LONG))
            begin
                ebusy_next = 1'b0;
                eto_next   = 1'b1;
                etp_next   = 1'b1;
                ev[HCS_I_EEP_TO] = 1'b1;
            end
            else
                ecnt_next = ecnt_reg + TW'(1);
        end

        if (i_detach_event)
        begin
            det_next = 1'b1;
            ev[HCS_I_DETACH] = 1'b1;
        end
        sts_next = sts_next | ev;

        // pin follows the fields whatever the eeprom state
        case (sel_next)
            2'b00:   act = i_low_power && i_power_state == 2'h2;
            2'b01:   act = (i_low_power && (i_power_state == 2'h2
                           || i_power_state == 2'h1)) || i_cable_detach;
            2'b10:   act = (i_low_power && i_power_state != 2'h3)
                           || i_cable_detach;
            default: act = i_low_power || i_cable_detach;
        endcase
        susp_next = act ? pol_next : ~pol_next;

        // read data from next values so a read right after a write is fresh
        rd_next = 32'h0000_0000;
        if (ap && !i_hwrite)
        begin
            if (rh[0])
            begin
                rd_next[HCS_B_LED +: 4]      = led_next;
                rd_next[HCS_B_DETACH]        = det_next;
                rd_next[HCS_B_SUSP_SEL +: 2] = sel_next;
                rd_next[HCS_B_SUSP_POL]      = pol_next;
                rd_next[HCS_B_MFP]           = mfp_next;
                rd_next[HCS_B_TO_SEL]        = tos_next;
                rd_next[HCS_B_LITE_RST] = seq_next == HCS_SEQ_LITE;
                rd_next[HCS_B_FULL_RST] = seq_next == HCS_SEQ_FULL;
            end
            if (rh[1])
            begin
                rd_next[HCS_B_EEP_TO]   = eto_next;
                rd_next[HCS_B_EEP_BUSY] = ebusy_next;
            end
            if (rh[2])
                rd_next[HCS_IRQ_W-1:0] = sts_next;
            if (rh[3])
                rd_next[HCS_IRQ_W-1:0] = en_next;
        end
    end

    always_ff @(posedge i_clk or negedge rst_b_reg)
    begin
        if (!rst_b_reg)
        begin
            sel_reg          <= HCS_RST_SEL;
            pol_reg          <= HCS_RST_POL;
            led_reg          <= HCS_RST_LED;
            mfp_reg          <= HCS_RST_MFP;
            tos_reg          <= HCS_RST_TO;
            det_reg          <= 1'b0;
            isel_reg         <= HCS_RST_SEL;
            ipol_reg         <= HCS_RST_POL;
            iled_reg         <= HCS_RST_LED;
            booted_reg       <= 1'b0;
            seq_reg          <= HCS_SEQ_IDLE;
            eto_reg          <= 1'b0;
            ebusy_reg        <= 1'b0;
            ecnt_reg         <= '0;
            sts_reg          <= HCS_RST_IRQ;
            en_reg           <= HCS_RST_IRQ;
            wp_reg           <= 1'b0;
            wh_reg           <= 5'h00;
            o_hrdata         <= 32'h0000_0000;
            o_hreadyout      <= 1'b1;
            o_hresp          <= 1'b0;
            o_lite_reset     <= 1'b0;
            o_full_reset     <= 1'b0;
            o_phy_disconnect <= 1'b0;
            o_eeprom_reload  <= 1'b0;
            o_eep_timeout    <= 1'b0;
            o_suspend_pin    <= 1'b1;
            o_multi_frame    <= 1'b0;
            o_led_enable     <= 4'h0;
            o_irq            <= 1'b0;
        end
        else if (i_ce)
        begin
            sel_reg          <= sel_next;
            pol_reg          <= pol_next;
            led_reg          <= led_next;
            mfp_reg          <= mfp_next;
            tos_reg          <= tos_next;
            det_reg          <= det_next;
            isel_reg         <= isel_next;
            ipol_reg         <= ipol_next;
            iled_reg         <= iled_next;
            booted_reg       <= booted_next;
            seq_reg          <= seq_next;
            eto_reg          <= eto_next;
            ebusy_reg        <= ebusy_next;
            ecnt_reg         <= ecnt_next;
            sts_reg          <= sts_next;
            en_reg           <= en_next;
            wp_reg           <= wp_next;
            wh_reg           <= wh_next;
            o_hrdata         <= rd_next;
            o_hreadyout      <= 1'b1;
            o_hresp          <= 1'b0;
            o_lite_reset     <= seq_next == HCS_SEQ_LITE;
            o_full_reset     <= seq_next == HCS_SEQ_FULL;
            o_phy_disconnect <= seq_next == HCS_SEQ_FULL;
            o_eeprom_reload  <= rld_next;
            o_eep_timeout    <= etp_next;
            o_suspend_pin    <= susp_next;
            o_multi_frame    <= mfp_next;
            o_led_enable     <= led_next;
            o_irq            <= |(sts_next & en_next);
        end
    end
endmodule

// file: sim/hcs_checker.sv
`timescale 1ns/10ps
module hcs_checker
(
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_ce,
    input  wire logic i_full_done,
    input  wire logic i_lite_done,
    input  wire logic o_hreadyout,
    input  wire logic o_hresp,
    input  wire logic o_lite_reset,
    input  wire logic o_full_reset,
    input  wire logic o_phy_disconnect,
    input  wire logic o_eeprom_reload,
    input  wire logic o_eep_timeout
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_full_disc: assert property (o_full_reset |-> o_phy_disconnect)
        else $error("phy connected during full reset");
    a_disc_release: assert property (!o_full_reset |-> !o_phy_disconnect)
        else $error("phy still disconnected after full reset");
    a_lite_keeps_phy: assert property (
        o_lite_reset |-> !o_phy_disconnect && !o_eeprom_reload)
        else $error("lite reset touched phy or reload");
    a_reload_start: assert property ($rose(o_full_reset) |-> o_eeprom_reload)
        else $error("no reload at full reset start");
    a_reload_once: assert property (o_eeprom_reload |=> !o_eeprom_reload)
        else $error("reload pulse longer than one cycle");
    a_full_holds: assert property (
        o_full_reset && !i_full_done |=> o_full_reset)
        else $error("full reset dropped before done");
    a_full_clears: assert property (
        o_full_reset && i_full_done && i_ce |=> !o_full_reset)
        else $error("full reset not cleared after done");
    a_lite_holds: assert property (
        o_lite_reset && !i_lite_done |=> o_lite_reset)
        else $error("lite reset dropped before done");
    a_lite_clears: assert property (
        o_lite_reset && i_lite_done && i_ce |=> !o_lite_reset)
        else $error("lite reset not cleared after done");
    a_timeout_pulse: assert property (
        o_eep_timeout |=> (!o_eep_timeout) [*8])
        else $error("time-out pulse repeated too soon");
    a_bus_okay: assert property (o_hreadyout && !o_hresp)
        else $error("bus slave stalled or erred");
endmodule

bind hcs_top hcs_checker hcs_checker_i (.*);

// file: sim/tb_hcs_top.sv
`timescale 1ns/10ps
module tb_hcs_top
    import hcs_pkg::*;
;
    logic        i_clk, i_rst_b, i_ce, i_hsel, i_hwrite, i_hready, i_low_power;
    logic        i_cable_detach, i_detach_event, i_image_load, i_image_valid;
    logic        i_image_pol, i_usb_reset, i_reset_guard, i_lite_done;
    logic        i_full_done, i_eep_start, i_eep_resp, o_hreadyout, o_hresp;
    logic        o_lite_reset, o_full_reset, o_phy_disconnect, o_eeprom_reload;
    logic        o_eep_timeout, o_suspend_pin, o_multi_frame, o_irq;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
    logic [1:0]  i_htrans, i_power_state, i_image_sel;
    logic [2:0]  i_hsize;
    logic [3:0]  i_image_led, o_led_enable;
    int          n_mismatch, checks_done, cycles;

    // 300 keeps the long eeprom limit above the short one but quick to reach
    hcs_top #(.TO_LONG_CYC(300)) hcs_top_i (.*);
    assign i_hready = o_hreadyout;

    always #2.5 i_clk = ~i_clk;

    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // ready and read data are taken at the rising edge that ends a phase
    task automatic wait_rdy;
        logic rdy;
        do
        begin
            @(posedge i_clk);
            rdy = o_hreadyout;
            rd = o_hrdata;
        end
        while (rdy !== 1'b1);
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_hwrite <= w;
        i_haddr <= {24'h0, a};
        wait_rdy();
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= d;
        wait_rdy();
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
        bus(1'b0, a, 32'h0);
        chk(rd, e, m);
    endtask

    localparam int P_LOAD  = 0;
    localparam int P_USB   = 1;
    localparam int P_LITE  = 2;
    localparam int P_FULL  = 3;
    localparam int P_START = 4;
    localparam int P_RESP  = 5;
    localparam int P_DET   = 6;

    task automatic set_line(input int k, input logic v);
        case (k)
            P_LOAD:  i_image_load <= v;
            P_USB:   i_usb_reset <= v;
            P_LITE:  i_lite_done <= v;
            P_FULL:  i_full_done <= v;
            P_START: i_eep_start <= v;
            P_RESP:  i_eep_resp <= v;
            default: i_detach_event <= v;
        endcase
    endtask

    task automatic pulse(input int k);
        @(posedge i_clk);
        set_line(k, 1'b1);
        @(posedge i_clk);
        set_line(k, 1'b0);
    endtask

    function automatic logic asserted(input int s, input int k);
        case (k)
            0: return s >= 2;
            1: return s >= 1;
            2: return 1'b1;
            3: return s == 3;
            default: return s != 0;
        endcase
    endfunction

    task automatic tmo(input int lim, input string m);
        int n;
        pulse(P_START);
        n = 0;
        do
        begin
            @(negedge i_clk);
            n++;
        end
        while (o_eep_timeout !== 1'b1 && n < 400);
        chk(32'(n >= lim - 1 && n <= lim + 3), 32'h1, m);
    endtask

    task automatic t_basic;
        rdc(HCS_OFF_CONFIG, 32'h0, "cfg reset");
        rdc(HCS_OFF_IRQ_STS, 32'h0, "status reset");
        chk(32'(o_suspend_pin), 32'h1, "pin idle low pol");
        bus(1'b1, 8'h80, 32'hFFFF_FFFC);
        rdc(8'h80, 32'h0, "unmapped read");
        rdc(HCS_OFF_CONFIG, 32'h0, "cfg untouched");
        pulse(P_LOAD);
        rdc(HCS_OFF_CONFIG, 32'h00A0_0060, "image fields");
        chk(32'(o_led_enable), 32'hA, "led from image");
        bus(1'b1, HCS_OFF_CONFIG, 32'h0000_0FFC);
        rdc(HCS_OFF_CONFIG, 32'h0000_00F8, "reserved bits");
        chk(32'(o_multi_frame), 32'h1, "packing on");
    endtask

    task automatic t_suspend;
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b1, HCS_OFF_CONFIG, 32'((s << 6) | ((s % 2) << 5)));
            for (int k = 0; k < 5; k++)
            begin
                @(posedge i_clk);
                i_low_power <= (k < 4);
                i_power_state <= 2'(k);
                i_cable_detach <= (k == 4);
                repeat (3) @(posedge i_clk);
                @(negedge i_clk);
                chk(32'(o_suspend_pin), 32'(!(asserted(s, k) ^ (s % 2))),
                    "suspend pin");
            end
        end
        @(posedge i_clk);
        i_low_power <= 1'b0;
        i_cable_detach <= 1'b0;
    endtask

    task automatic t_resets;
        bus(1'b1, HCS_OFF_CONFIG, 32'h18);
        bus(1'b1, HCS_OFF_CONFIG, 32'h2);
        @(negedge i_clk);
        chk(32'({o_lite_reset, o_phy_disconnect, o_eeprom_reload}), 32'h4,
            "lite start");
        rdc(HCS_OFF_CONFIG, 32'h00A0_0062, "lite start image");
        bus(1'b1, HCS_OFF_CONFIG, 32'h00A0_0061);
        rdc(HCS_OFF_CONFIG, 32'h00A0_0062, "lite running");
        pulse(P_LITE);
        @(negedge i_clk);
        chk(32'(o_lite_reset | o_full_reset), 32'h0, "lite end");
        rdc(HCS_OFF_CONFIG, 32'h00A0_0060, "lite restore");
        bus(1'b1, HCS_OFF_CONFIG, 32'h00A0_0079);
        @(negedge i_clk);
        chk(32'({o_full_reset, o_phy_disconnect, o_eeprom_reload}), 32'h7,
            "full start");
        rdc(HCS_OFF_CONFIG, 32'h00A0_0061, "full running");
        pulse(P_FULL);
        @(negedge i_clk);
        chk(32'(o_full_reset | o_phy_disconnect), 32'h0, "full end");
        rdc(HCS_OFF_CONFIG, 32'h00A0_0060, "full cleared");
        rdc(HCS_OFF_IRQ_STS, 32'h6, "done status");
        chk(32'(o_irq), 32'h0, "irq masked");
        bus(1'b1, HCS_OFF_IRQ_EN, 32'h4);
        repeat (2) @(negedge i_clk);
        chk(32'(o_irq), 32'h1, "irq raised");
        bus(1'b1, HCS_OFF_IRQ_CLR, 32'h6);
        repeat (2) @(negedge i_clk);
        chk(32'(o_irq), 32'h0, "irq cleared");
    endtask

    task automatic t_timeout;
        bus(1'b1, HCS_OFF_CONFIG, 32'h00A0_0068);
        bus(1'b1, HCS_OFF_IRQ_EN, 32'h1);
        tmo(256, "short limit");
        bus(1'b0, HCS_OFF_EEP_CMD, 32'h0);
        chk(rd & 32'h1, 32'h1, "flag set");
        chk(32'(o_irq), 32'h1, "timeout irq");
        bus(1'b1, HCS_OFF_EEP_CMD, 32'h1);
        bus(1'b0, HCS_OFF_EEP_CMD, 32'h0);
        chk(rd & 32'h1, 32'h0, "flag cleared");
        bus(1'b1, HCS_OFF_IRQ_CLR, 32'h1);
        pulse(P_START);
        repeat (10) @(posedge i_clk);
        pulse(P_RESP);
        repeat (400) @(negedge i_clk)
            if (o_eep_timeout === 1'b1)
                chk(32'h1, 32'h0, "timeout despite answer");
        bus(1'b1, HCS_OFF_CONFIG, 32'h00A0_0060);
        tmo(300, "long limit");
        pulse(P_DET);
        rdc(HCS_OFF_CONFIG, 32'h00A0_8060, "detach seen");
        bus(1'b1, HCS_OFF_CONFIG, 32'h00A0_8060);
        rdc(HCS_OFF_CONFIG, 32'h00A0_0060, "detach cleared");
    endtask

    task automatic t_guard;
        @(posedge i_clk);
        i_reset_guard <= 1'b1;
        bus(1'b1, HCS_OFF_CONFIG, 32'hC0);
        pulse(P_USB);
        pulse(P_LOAD);
        bus(1'b1, HCS_OFF_CONFIG, 32'hC2);
        pulse(P_LITE);
        rdc(HCS_OFF_CONFIG, 32'hC0, "guard keeps");
        @(posedge i_clk);
        i_reset_guard <= 1'b0;
        pulse(P_USB);
        rdc(HCS_OFF_CONFIG, 32'h00A0_0060, "usb restore");
        @(posedge i_clk);
        i_image_valid <= 1'b0;
        pulse(P_LOAD);
        pulse(P_USB);
        rdc(HCS_OFF_CONFIG, 32'h0, "no image zero");
        @(posedge i_clk);
        i_low_power <= 1'b1;
        i_power_state <= 2'h2;
        repeat (3) @(negedge i_clk);
        chk(32'(o_suspend_pin), 32'h0, "pin without image");
    endtask

    initial
    begin
        {i_clk, i_rst_b, i_hsel, i_hwrite, i_low_power, i_cable_detach} = '0;
        {i_detach_event, i_image_load, i_usb_reset, i_reset_guard} = '0;
        {i_lite_done, i_full_done, i_eep_start, i_eep_resp} = '0;
        {i_ce, i_image_valid, i_image_pol} = 3'h7;
        i_haddr = 32'h0;
        i_hwdata = 32'h0;
        i_htrans = 2'h0;
        i_hsize = 3'h2;
        i_power_state = 2'h0;
        i_image_sel = 2'h1;
        i_image_led = 4'hA;
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clk);
        t_basic();
        t_suspend();
        t_resets();
        t_timeout();
        t_guard();
        conclude();
    end
endmodule
